// file: logic/wdt_pkg.sv
/*
 * wdt_pkg: register map, field positions, reset values and timing counts
 * for the watchdog timer control block.
 * assumes a single 100 MHz system clock and a plain register port.
 */
package wdt_pkg;
	// register offsets on the plain register port
	localparam logic [3:0] WDT_ADDR_CTRL = 4'h0;   // watchdog_control
	localparam logic [3:0] WDT_ADDR_CLKCFG = 4'h1; // interval select bits
	localparam logic [3:0] WDT_ADDR_KEY = 4'h2;    // timed_access_key
	localparam logic [3:0] WDT_ADDR_IRQEN = 4'h3;  // irq enables
	localparam logic [3:0] WDT_ADDR_ISTAT = 4'h4;  // sticky event status
	localparam logic [3:0] WDT_ADDR_IMASK = 4'h5;  // event mask
	localparam logic [3:0] WDT_ADDR_CNT0 = 4'h6;   // counter bits 7:0
	localparam logic [3:0] WDT_ADDR_CNT1 = 4'h7;   // counter bits 15:8
	localparam logic [3:0] WDT_ADDR_CNT2 = 4'h8;   // counter bits 23:16
	localparam logic [3:0] WDT_ADDR_CNT3 = 4'h9;   // counter bits 25:24

	// watchdog_control fields
	localparam int WDT_CTRL_RESTART = 0;
	localparam int WDT_CTRL_RST_EN = 1;
	localparam int WDT_CTRL_CAUSE = 2;
	localparam int WDT_CTRL_TOFLAG = 3;
	// clock config fields (interval select hi/lo)
	localparam int WDT_CLK_SEL_LO = 6;
	localparam int WDT_CLK_SEL_HI = 7;
	// irq enable fields
	localparam int WDT_IRQEN_WD = 4;
	localparam int WDT_IRQEN_GLOBAL = 7;
	// status/mask fields
	localparam int WDT_IST_TIMEOUT = 0;
	localparam int WDT_IST_WDRESET = 1;

	localparam logic [1:0] WDT_SEL_RESET = 2'h0; // shortest interval

	// timed access keys and unlock window
	localparam logic [7:0] WDT_KEY_FIRST = 8'haa;
	localparam logic [7:0] WDT_KEY_SECOND = 8'h55;
	localparam logic [2:0] WDT_UNLOCK_CYCLES = 3'h4;

	// counter and interval stages (2^17, 2^20, 2^23, 2^26 clocks)
	localparam int WDT_CNT_W = 26;
	localparam int WDT_STAGE0 = 17;
	localparam int WDT_STAGE1 = 20;
	localparam int WDT_STAGE2 = 23;
	localparam int WDT_STAGE3 = 26;
	localparam int WDT_GRACE_CLOCKS = 512;
	localparam logic [9:0] WDT_GRACE_CNT = 10'(WDT_GRACE_CLOCKS);

	// reset pulse: two machine cycles of twelve clocks each
	localparam int WDT_MC_CLOCKS = 12;
	localparam logic [4:0] WDT_RST_PULSE = 5'(2 * WDT_MC_CLOCKS);

	typedef enum logic [1:0] {
		WDT_ST_OFF = 2'b00,
		WDT_ST_RUN = 2'b01,
		WDT_ST_GRACE = 2'b10,
		WDT_ST_RST = 2'b11
	} wdt_state_t;
endpackage : wdt_pkg

// file: logic/wdt_ctrl.sv
/*
 * wdt_ctrl: watchdog timer control with timed-access protected control bits,
 * selectable interval, time-out flag, delayed system reset and sticky irq.
 * register map on the plain port (index: contents):
 *   0 watchdog_control: bit3 time-out flag, bit2 reset cause,
 *     bit1 reset enable, bit0 restart (write only, always reads zero)
 *   1 clock config: bits 7:6 interval select
 *   2 timed_access_key: write aa then 55; reads the unlock and key state
 *   3 irq enables: bit7 global, bit4 watchdog
 *   4 event status, write one to clear: bit0 time-out, bit1 watchdog reset
 *   5 event mask, same layout as the status
 *   6..9 live divider count, low byte first; not latched, so a read may tear
 * the timer stays off after a power reset until the first unlocked restart,
 * and after its own reset pulse it restarts counting from zero by itself.
 * flags, status and select clear on any reset; the cause flag survives the
 * general and power-on resets so software can still see why the part restarted,
 * and only a power-fail reset or a watchdog_control write with bit2 low clears it.
 * assumes power-on and power-fail resets arrive synchronous to clk_i, and that
 * the register master obeys the one-cycle strobe protocol.
 * assumes the power-fail reset is raised at first power-up, since nothing else
 * gives the cause flag a defined value.
 * assumes wd_sys_rst_o is looped back into srst_i outside the block when the
 * watchdog reset is to reach the rest of the system.
 */
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/10ps
module wdt_ctrl (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic por_rst_i,
	input wire logic pfail_rst_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	output logic wd_sys_rst_o,
	output logic wd_irq_req_o,
	output logic irq_o
);
	import wdt_pkg::*;

	// state, divider and reset pulse
	wdt_state_t state_reg, state_next;
	logic [WDT_CNT_W-1:0] cnt_reg, cnt_next;
	logic [9:0] grace_reg, grace_next;
	logic [4:0] pulse_reg, pulse_next;
	// control bits and interrupt enables
	logic [1:0] sel_reg, sel_next;
	logic rst_en_reg, rst_en_next;
	logic toflag_reg, toflag_next;
	logic cause_reg, cause_next;
	logic wd_ie_reg, wd_ie_next;
	logic gie_reg, gie_next;
	// timed-access sequencer
	logic [1:0] key_reg, key_next;
	logic [2:0] win_reg, win_next;
	// event status, mask, read port and interrupt outputs
	logic [1:0] ist_reg, ist_next;
	logic [1:0] imask_reg, imask_next;
	logic [7:0] rdata_reg, rdata_next;
	logic irq_reg, irq_next;
	logic wdirq_reg, wdirq_next;
	logic sysrst_reg, sysrst_next;

	// decoded strobes and events
	logic any_rst;
	logic hard_rst;
	logic wr_ctrl;
	logic unlocked;
	logic restart;
	logic timeout;
	logic stage_bit;
	logic wd_fire;
	logic grace_end;
	logic [3:0] stage_hit;

	// one roll-over tap per selectable interval
	wdt_stage_tap #(
		.WIDTH(WDT_STAGE0)
	) u_tap0 (
		.bits_i(cnt_reg[WDT_STAGE0-1:0]),
		.hit_o(stage_hit[0])
	);
	wdt_stage_tap #(
		.WIDTH(WDT_STAGE1)
	) u_tap1 (
		.bits_i(cnt_reg[WDT_STAGE1-1:0]),
		.hit_o(stage_hit[1])
	);
	wdt_stage_tap #(
		.WIDTH(WDT_STAGE2)
	) u_tap2 (
		.bits_i(cnt_reg[WDT_STAGE2-1:0]),
		.hit_o(stage_hit[2])
	);
	wdt_stage_tap #(
		.WIDTH(WDT_STAGE3)
	) u_tap3 (
		.bits_i(cnt_reg[WDT_STAGE3-1:0]),
		.hit_o(stage_hit[3])
	);

	// decode strobes and the selected divider stage
	always_comb begin
		hard_rst = por_rst_i | pfail_rst_i;
		any_rst = srst_i | hard_rst;
		wr_ctrl = wr_i && (addr_i == WDT_ADDR_CTRL);
		unlocked = (win_reg != 3'h0);
		restart = wr_ctrl && unlocked && wdata_i[WDT_CTRL_RESTART];
		unique case (sel_reg)
			2'b00: stage_bit = stage_hit[0];
			2'b01: stage_bit = stage_hit[1];
			2'b10: stage_bit = stage_hit[2];
			2'b11: stage_bit = stage_hit[3];
		endcase
		timeout = (state_reg != WDT_ST_OFF) && (state_reg != WDT_ST_RST) && !restart && stage_bit;
		// fire 512 clocks after the time-out
		// last clock of the grace span, counted from the time-out edge
		grace_end = (grace_reg == WDT_GRACE_CNT - 10'h1);
		wd_fire = (state_reg == WDT_ST_GRACE) && !restart && rst_en_reg && grace_end;
	end

	// timed-access key sequencer: AAH arms, 55H opens a short window
	always_comb begin
		key_next = key_reg;
		win_next = (win_reg != 3'h0) ? win_reg - 3'h1 : 3'h0;
		if (wr_i && addr_i == WDT_ADDR_KEY) begin
			if (wdata_i == WDT_KEY_FIRST) begin
				key_next = 2'h1;
			end else if (wdata_i == WDT_KEY_SECOND && key_reg == 2'h1) begin
				key_next = 2'h0;
				win_next = WDT_UNLOCK_CYCLES;
			end else begin
				// any other byte disarms, so a stray write cannot half-open the lock
				key_next = 2'h0;
			end
		end
		// a protected write uses up the window
		if (wr_ctrl) begin
			win_next = 3'h0;
		end
		// every reset closes the lock
		if (any_rst) begin
			key_next = 2'h0;
			win_next = 3'h0;
		end
	end

	// counter, state and reset pulse
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg + 26'h1;
		grace_next = grace_reg;
		pulse_next = pulse_reg;
		sysrst_next = 1'b0;
		unique case (state_reg)
			WDT_ST_OFF: begin
				// stays idle until software restarts it
				cnt_next = '0;
				if (restart) begin
					state_next = WDT_ST_RUN;
				end
			end
			WDT_ST_RUN: begin
				if (timeout) begin
					state_next = WDT_ST_GRACE;
					grace_next = 10'h0;
				end
			end
			WDT_ST_GRACE: begin
				grace_next = grace_reg + 10'h1;
				// without reset enable timer simply keeps running
				// the divider keeps counting; a fresh time-out restarts the grace span
				if (timeout) begin
					grace_next = 10'h0;
				end else if (wd_fire) begin
					state_next = WDT_ST_RST;
					pulse_next = WDT_RST_PULSE - 5'h1;
					sysrst_next = 1'b1;
				end else if (grace_end) begin
					state_next = WDT_ST_RUN;
				end
			end
			WDT_ST_RST: begin
				// hold reset for two machine cycles
				sysrst_next = (pulse_reg != 5'h0);
				pulse_next = pulse_reg - 5'h1;
				cnt_next = '0;
				if (pulse_reg == 5'h0) begin
					state_next = WDT_ST_RUN;
				end
			end
		endcase
		if (restart && state_reg != WDT_ST_RST) begin
			cnt_next = '0;
			state_next = WDT_ST_RUN;
		end
		// hard resets disable; srst clears the count and sends a live timer back to RUN
		if (hard_rst) begin
			state_next = WDT_ST_OFF;
			cnt_next = '0;
			sysrst_next = 1'b0;
		end else if (srst_i) begin
			cnt_next = '0;
			if (state_reg != WDT_ST_OFF) begin
				state_next = WDT_ST_RUN;
			end
			sysrst_next = 1'b0;
		end
	end

	// control bits and flags
	always_comb begin
		sel_next = sel_reg;
		rst_en_next = rst_en_reg;
		toflag_next = toflag_reg;
		cause_next = cause_reg;
		wd_ie_next = wd_ie_reg;
		gie_next = gie_reg;
		imask_next = imask_reg;
		ist_next = ist_reg;
		if (wr_i && addr_i == WDT_ADDR_CLKCFG) begin
			sel_next = {wdata_i[WDT_CLK_SEL_HI], wdata_i[WDT_CLK_SEL_LO]};
		end
		if (wr_i && addr_i == WDT_ADDR_IRQEN) begin
			wd_ie_next = wdata_i[WDT_IRQEN_WD];
			gie_next = wdata_i[WDT_IRQEN_GLOBAL];
		end
		if (wr_i && addr_i == WDT_ADDR_IMASK) begin
			imask_next = wdata_i[1:0];
		end
		if (wr_i && addr_i == WDT_ADDR_ISTAT) begin
			ist_next = ist_reg & ~wdata_i[1:0];
		end
		if (wr_ctrl) begin
			// cause flag written by software, no unlock needed
			cause_next = wdata_i[WDT_CTRL_CAUSE];
			if (unlocked) begin
				rst_en_next = wdata_i[WDT_CTRL_RST_EN];
				toflag_next = wdata_i[WDT_CTRL_TOFLAG];
			end
		end
		// events come after the software writes so a same-cycle set wins
		// time-out sets flag, set beats clear
		if (timeout) begin
			toflag_next = 1'b1;
			ist_next[WDT_IST_TIMEOUT] = 1'b1;
		end
		// cause flag only when reset is enabled
		if (wd_fire) begin
			cause_next = 1'b1;
			ist_next[WDT_IST_WDRESET] = 1'b1;
		end
		// any reset clears flag and sel
		if (any_rst) begin
			toflag_next = 1'b0;
			sel_next = WDT_SEL_RESET;
			ist_next = 2'h0;
		end
		// power resets also drop the enables and the mask
		if (hard_rst) begin
			rst_en_next = 1'b0;
			wd_ie_next = 1'b0;
			gie_next = 1'b0;
			imask_next = 2'h0;
		end
		if (pfail_rst_i) begin
			cause_next = 1'b0;
		end
	end

	// read mux, outputs registered; restart always reads back zero
	always_comb begin
		rdata_next = 8'h00;
		if (rd_i) begin
			unique case (addr_i)
				// restart bit is not stored, so it always reads zero
				WDT_ADDR_CTRL: rdata_next = {4'h0, toflag_reg, cause_reg, rst_en_reg, 1'b0};
				WDT_ADDR_CLKCFG: rdata_next = {sel_reg, 6'h00};
				WDT_ADDR_KEY: rdata_next = {5'h00, unlocked, key_reg};
				WDT_ADDR_IRQEN: rdata_next = {gie_reg, 2'h0, wd_ie_reg, 4'h0};
				WDT_ADDR_ISTAT: rdata_next = {6'h00, ist_reg};
				WDT_ADDR_IMASK: rdata_next = {6'h00, imask_reg};
				WDT_ADDR_CNT0: rdata_next = cnt_reg[7:0];
				WDT_ADDR_CNT1: rdata_next = cnt_reg[15:8];
				WDT_ADDR_CNT2: rdata_next = cnt_reg[23:16];
				WDT_ADDR_CNT3: rdata_next = {6'h00, cnt_reg[25:24]};
				default: rdata_next = 8'h00;
			endcase
		end
		wdirq_next = toflag_next & wd_ie_next & gie_next;
		irq_next = |(ist_next & imask_next);
	end

	// key group; all resets live in the next-value logic
	always_ff @(posedge clk_i) begin
		key_reg <= key_next;
		win_reg <= win_next;
	end

	// state, divider and reset pulse group
	always_ff @(posedge clk_i) begin
		state_reg <= state_next;
		cnt_reg <= cnt_next;
		grace_reg <= grace_next;
		pulse_reg <= pulse_next;
		sysrst_reg <= sysrst_next;
	end

	// control bits and flags group
	always_ff @(posedge clk_i) begin
		sel_reg <= sel_next;
		rst_en_reg <= rst_en_next;
		toflag_reg <= toflag_next;
		cause_reg <= cause_next;
		wd_ie_reg <= wd_ie_next;
		gie_reg <= gie_next;
		ist_reg <= ist_next;
		imask_reg <= imask_next;
	end

	// read port and interrupt group
	always_ff @(posedge clk_i) begin
		rdata_reg <= rdata_next;
		irq_reg <= irq_next;
		wdirq_reg <= wdirq_next;
	end

	// outputs come straight from their flops
	assign rdata_o = rdata_reg;
	assign wd_sys_rst_o = sysrst_reg;
	assign wd_irq_req_o = wdirq_reg;
	assign irq_o = irq_reg;
endmodule : wdt_ctrl

// all-ones detector on the low bits of the divider
module wdt_stage_tap
	import wdt_pkg::*;
#(
	parameter int WIDTH = WDT_STAGE0
) (
	input wire logic [WIDTH-1:0] bits_i,
	output logic hit_o
);
	// a stage rolls over on the clock after its low bits are all ones
	always_comb begin
		hit_o = (bits_i == '1);
	end
endmodule : wdt_stage_tap

// file: testbench/wdt_ctrl_props.sv
/* wdt_ctrl_props: port assertions for wdt_ctrl.
   assumes a bind to every wdt_ctrl instance. */
`timescale 1ns/10ps
module wdt_ctrl_props
	import wdt_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic por_rst_i,
	input wire logic pfail_rst_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic wd_sys_rst_o,
	input wire logic wd_irq_req_o,
	input wire logic irq_o
);
	logic [4:0] hi_reg;
	logic [4:0] hi_next;
	// length of the running reset pulse; wraps after 31, and a pulse that never falls is not caught below
	always_comb begin
		hi_next = wd_sys_rst_o ? hi_reg + 5'h01 : 5'h00;
	end
	always_ff @(posedge clk_i) begin
		hi_reg <= hi_next;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	a_rd_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data outside its slot");
	a_unmapped_zero: assert property ($past(rd_i) && $past(addr_i) > WDT_ADDR_CNT3
		|-> rdata_o == 8'h00) else $error("unmapped read not zero");
	a_restart_self_clear: assert property (
		$past(rd_i) && $past(addr_i) == WDT_ADDR_CTRL |-> !rdata_o[WDT_CTRL_RESTART])
		else $error("restart bit read back set");
	a_pulse_len: assert property ($fell(wd_sys_rst_o) |-> hi_reg == 5'h18)
		else $error("reset pulse length wrong");
	a_pulse_gap: assert property ($fell(wd_sys_rst_o) |-> !wd_sys_rst_o [*8])
		else $error("reset pulse repeated at once");
	a_power_quiet: assert property ((por_rst_i || pfail_rst_i) |=> !wd_sys_rst_o [*8])
		else $error("reset pulse after power reset");
	a_release_low: assert property ($fell(srst_i) |-> !wd_irq_req_o && !irq_o)
		else $error("irq high after reset");
	a_irq_en_gate: assert property (
		wr_i && addr_i == WDT_ADDR_IRQEN && !wdata_i[WDT_IRQEN_WD] |-> ##[1:2] !wd_irq_req_o)
		else $error("irq request ignores enable");
	a_status_clear: assert property (wr_i && addr_i == WDT_ADDR_ISTAT && wdata_i == 8'h03
		|-> ##[1:2] !irq_o) else $error("status clear ignored");
endmodule : wdt_ctrl_props
bind wdt_ctrl wdt_ctrl_props u_props (.clk_i, .srst_i, .por_rst_i, .pfail_rst_i, .addr_i,
	.wdata_i, .wr_i, .rd_i, .rdata_o, .wd_sys_rst_o, .wd_irq_req_o, .irq_o);

// file: testbench/tb.sv
/* tb: register-level test of wdt_ctrl.
   assumes the props checker is bound in. */
`timescale 1ns/10ps
module tb;
	import wdt_pkg::*;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic por_rst_i = 1'b1;
	logic pfail_rst_i = 1'b1; // power-up raises both power resets
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] rdata_o;
	logic wd_sys_rst_o;
	logic wd_irq_req_o;
	logic irq_o;
	logic [7:0] d;
	int n_mismatch = 0;
	int tests_run = 0;
	int n;
	wdt_ctrl dut (.clk_i, .srst_i, .por_rst_i, .pfail_rst_i, .addr_i, .wdata_i, .wr_i,
		.rd_i, .rdata_o, .wd_sys_rst_o, .wd_irq_req_o, .irq_o);
	// 100 MHz
	always begin
		#5 clk_i = ~clk_i;
	end
	task chk(input string s, input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", s, exp, got);
		end
	endtask : chk
	task finish_test();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : finish_test
	// tasks start just after an edge; wr leaves its strobe up until the next task drops it
	task wr(input logic [3:0] a, input logic [7:0] v);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		rd_i <= 1'b0;
		@(posedge clk_i);
	endtask : wr
	task rd(input logic [3:0] a);
		addr_i <= a;
		rd_i <= 1'b1;
		wr_i <= 1'b0;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		d = rdata_o;
		@(posedge clk_i);
	endtask : rd
	task cyc(input int k);
		wr_i <= 1'b0;
		rd_i <= 1'b0;
		repeat (k) @(posedge clk_i);
	endtask : cyc
	task unlock(input logic [7:0] v);
		wr(WDT_ADDR_KEY, WDT_KEY_FIRST);
		wr(WDT_ADDR_KEY, WDT_KEY_SECOND);
		wr(WDT_ADDR_CTRL, v);
	endtask : unlock
	// one timeout takes about 131k cycles, so allow a margin above that
	initial begin
		repeat (200000) @(posedge clk_i);
		n_mismatch++;
		finish_test();
	end
	initial begin
		repeat (16) @(posedge clk_i);
		srst_i <= 1'b0;
		por_rst_i <= 1'b0;
		pfail_rst_i <= 1'b0;
		@(posedge clk_i);
		rd(WDT_ADDR_CTRL);
		chk("ctrl", d, 8'h00);
		rd(WDT_ADDR_CLKCFG);
		chk("sel", d, 8'h00);
		rd(4'hf);
		chk("unmapped", d, 8'h00);
		wr(WDT_ADDR_CTRL, 8'h03);
		cyc(20);
		rd(WDT_ADDR_CTRL);
		chk("locked", d, 8'h00);
		rd(WDT_ADDR_CNT0);
		chk("idle cnt", d, 8'h00);
		wr(WDT_ADDR_CLKCFG, 8'hc0);
		rd(WDT_ADDR_CLKCFG);
		chk("sel set", d, 8'hc0);
		wr(WDT_ADDR_CLKCFG, 8'h00);
		unlock(8'h03);
		rd(WDT_ADDR_CTRL);
		chk("run ctrl", d, 8'h02);
		cyc(300);
		rd(WDT_ADDR_CNT1);
		chk("run cnt", d, 8'h01);
		// unlock left to expire before the write
		wr(WDT_ADDR_KEY, WDT_KEY_FIRST);
		wr(WDT_ADDR_KEY, WDT_KEY_SECOND);
		cyc(10);
		wr(WDT_ADDR_CTRL, 8'h00);
		rd(WDT_ADDR_CTRL);
		chk("expired", d, 8'h02);
		unlock(8'h03);
		wr(WDT_ADDR_IRQEN, 8'h90);
		wr(WDT_ADDR_IMASK, 8'h03);
		rd(WDT_ADDR_CNT1);
		chk("restart", d, 8'h00);
		n = 0;
		while (wd_irq_req_o !== 1'b1 && n < 140000) begin
			@(negedge clk_i);
			n++;
		end
		chk("interval", {7'h00, n > 131050 && n < 131075}, 8'h01);
		n = 0;
		while (wd_sys_rst_o !== 1'b1 && n < 600) begin
			@(negedge clk_i);
			n++;
		end
		chk("grace", {7'h00, n >= 510 && n <= 514}, 8'h01);
		n = 0;
		while (wd_sys_rst_o === 1'b1 && n < 40) begin
			@(negedge clk_i);
			n++;
		end
		chk("pulse", 8'(n), 8'h18);
		chk("irq", {7'h00, irq_o}, 8'h01);
		@(posedge clk_i);
		rd(WDT_ADDR_CTRL);
		chk("cause", d, 8'h0e);
		wr(WDT_ADDR_ISTAT, 8'h03);
		wr(WDT_ADDR_IRQEN, 8'h00);
		cyc(3);
		@(negedge clk_i);
		chk("irq off", {6'h00, irq_o, wd_irq_req_o}, 8'h00);
		@(posedge clk_i);
		srst_i <= 1'b1;
		@(posedge clk_i);
		srst_i <= 1'b0;
		rd(WDT_ADDR_CTRL);
		rd(WDT_ADDR_CTRL);
		chk("kept", d & 8'h0d, 8'h04);
		cyc(300);
		rd(WDT_ADDR_CNT1);
		chk("still run", d, 8'h01);
		pfail_rst_i <= 1'b1;
		@(posedge clk_i);
		pfail_rst_i <= 1'b0;
		rd(WDT_ADDR_CTRL);
		chk("pfail", d, 8'h00);
		cyc(20);
		rd(WDT_ADDR_CNT0);
		chk("off cnt", d, 8'h00);
		finish_test();
	end
endmodule : tb
